// [core/rba_params.svh]
// Constants for the rebuild assist log page and its error report
`ifndef RBA_PARAMS_SVH
`define RBA_PARAMS_SVH

// Log address and page size
`define RBA_LOG_ADDR 8'h15
`define RBA_OFF_W 9

// Byte offsets inside the page (element length N = 2)
`define RBA_OFS_ENABLE 9'h000
`define RBA_OFS_LEN 9'h007
`define RBA_OFS_MASK_HI 9'h008
`define RBA_OFS_MASK_LO 9'h009
`define RBA_OFS_DIS_HI 9'h00A
`define RBA_OFS_DIS_LO 9'h00B

// Field positions and values
`define RBA_EN_BIT 0
`define RBA_ELEM_LEN 8'h02
`define RBA_ELEM_BITS 16
`define RBA_ELEM_IDX_W 4
`define RBA_ELEM_LAST 4'hF
`define RBA_ELEM_MASK 16'h0FFF
`define RBA_DIS_RESET 16'h0000

// Queued error log values for a predicted error
`define RBA_SENSE_KEY 4'hB
`define RBA_ASC_ASCQ 16'h1103
`define RBA_LBA_W 48

`endif

// [core/rba_pkg.sv]
// Types shared by the rebuild assist modules
`include "rba_params.svh"
package rba_pkg;
  typedef enum logic {MODE_IDLE, MODE_TEST} rba_mode_t;

  typedef struct packed {
    rba_mode_t mode;
    logic enabled;
    logic stg_en;
    logic [`RBA_ELEM_BITS-1:0] stg_dis;
    logic [`RBA_ELEM_BITS-1:0] dis;
    logic [7:0] rdata;
    logic rvalid;
    logic pred;
    logic unpred;
  } main_state_t;

  typedef struct packed {
    logic busy;
    logic [`RBA_ELEM_IDX_W-1:0] idx;
    logic [`RBA_ELEM_BITS-1:0] fail;
    logic done;
  } test_state_t;

  typedef struct packed {
    logic open;
    logic found;
    logic any_err;
    logic [`RBA_LBA_W-1:0] first;
    logic [`RBA_LBA_W-1:0] final_lba;
    logic done;
    logic o_err;
    logic o_found;
    logic o_report;
    logic [`RBA_LBA_W-1:0] o_first;
    logic [`RBA_LBA_W-1:0] o_final;
  } run_state_t;
endpackage : rba_pkg

// [core/rba_test_if.sv]
// Link between the log control and the element self test
`timescale 1ns/1ps
`default_nettype none
`include "rba_params.svh"
interface rba_test_if;
  logic start;
  logic [`RBA_ELEM_BITS-1:0] mask;
  logic done;
  logic [`RBA_ELEM_BITS-1:0] fail;

  modport ctl (output start, output mask, input done, input fail);
  modport tst (input start, input mask, output done, output fail);
endinterface : rba_test_if
`default_nettype wire

// [core/rba_self_test.sv]
// Walks every supported element through the media self test
`timescale 1ns/1ps
`default_nettype none
`include "rba_params.svh"
module rba_self_test (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control side
  rba_test_if.tst tif,
  // Media test port
  output logic elem_test_req,
  output logic [`RBA_ELEM_IDX_W-1:0] elem_test_idx,
  input wire logic elem_test_ack,
  input wire logic elem_test_ok
);
  rba_pkg::test_state_t s_r, s_nxt;

  // Unsupported elements are skipped in one cycle without a request
  assign elem_test_req = s_r.busy && tif.mask[s_r.idx];
  assign elem_test_idx = s_r.idx;
  assign tif.done = s_r.done;
  assign tif.fail = s_r.fail;

  // Walk and fail collection
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (tif.start) begin
      s_nxt.busy = 1'b1;
      s_nxt.idx = '0;
      s_nxt.fail = `RBA_DIS_RESET;
    end else if (s_r.busy && (!tif.mask[s_r.idx] || elem_test_ack)) begin
      if (tif.mask[s_r.idx] && !elem_test_ok) begin
        s_nxt.fail[s_r.idx] = 1'b1;
      end
      if (s_r.idx == `RBA_ELEM_LAST) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
      s_nxt.idx = s_r.idx + 4'h1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : rba_self_test
`default_nettype wire

// [core/rba_run_tracker.sv]
// Tracks the first predicted error run of one command
`timescale 1ns/1ps
`default_nettype none
`include "rba_params.svh"
module rba_run_tracker (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Per sector verdict
  input wire logic sec_valid,
  input wire logic sec_last,
  input wire logic [`RBA_LBA_W-1:0] sec_lba,
  input wire logic pred,
  input wire logic unpred,
  input wire logic report,
  // Command summary
  output logic done,
  output logic err,
  output logic found,
  output logic rep,
  output logic [`RBA_LBA_W-1:0] first_lba,
  output logic [`RBA_LBA_W-1:0] final_lba
);
  rba_pkg::run_state_t s_r, s_nxt;

  assign done = s_r.done;
  assign err = s_r.o_err;
  assign found = s_r.o_found;
  assign rep = s_r.o_report;
  assign first_lba = s_r.o_first;
  assign final_lba = s_r.o_final;

  // Run grows only while predicted sectors stay contiguous
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (sec_valid) begin
      if (pred && !s_r.found) begin
        s_nxt.found = 1'b1;
        s_nxt.open = 1'b1;
        s_nxt.first = sec_lba;
        s_nxt.final_lba = sec_lba;
      end else if (pred && s_r.open &&
                   sec_lba == s_r.final_lba + 48'h0000_0000_0001) begin
        s_nxt.final_lba = sec_lba;
      end else begin
        s_nxt.open = 1'b0;
      end
      s_nxt.any_err = s_r.any_err | pred | unpred;
      if (sec_last) begin
        s_nxt.done = 1'b1;
        s_nxt.o_err = s_nxt.any_err;
        s_nxt.o_found = s_nxt.found;
        s_nxt.o_report = report;
        s_nxt.o_first = s_nxt.first;
        s_nxt.o_final = s_nxt.final_lba;
        s_nxt.open = 1'b0;
        s_nxt.found = 1'b0;
        s_nxt.any_err = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : rba_run_tracker
`default_nettype wire

// [core/rba_log_control.sv]
// Rebuild assist log page, enable sequence and predicted error verdicts
`timescale 1ns/1ps
`default_nettype none
`include "rba_params.svh"
module rba_log_control (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Capability
  output logic feature_supported,
  // Log page access
  input wire logic [7:0] log_page,
  input wire logic log_rd,
  input wire logic log_wr,
  input wire logic [`RBA_OFF_W-1:0] log_off,
  input wire logic [7:0] log_wdata,
  input wire logic log_commit,
  output logic [7:0] log_rdata,
  output logic log_rvalid,
  output logic log_busy,
  // Element self test port
  output logic elem_test_req,
  output logic [`RBA_ELEM_IDX_W-1:0] elem_test_idx,
  input wire logic elem_test_ack,
  input wire logic elem_test_ok,
  // Sector stream of a command
  input wire logic sec_valid,
  input wire logic [`RBA_LBA_W-1:0] sec_lba,
  input wire logic [`RBA_ELEM_IDX_W-1:0] sec_elem,
  input wire logic sec_write,
  input wire logic rebuild_assist_bypass,
  input wire logic sec_media_err,
  input wire logic sec_last,
  // Per sector verdict
  output logic sec_pred_err,
  output logic sec_unpred_err,
  // Command completion and queued error log entry
  output logic cmd_done,
  output logic cmd_err,
  output logic qel_valid,
  output logic [3:0] qel_sense_key,
  output logic [15:0] qel_asc,
  output logic [`RBA_LBA_W-1:0] qel_lba,
  output logic [`RBA_LBA_W-1:0] qel_final_lba,
  // Feature state
  output logic feature_enabled,
  output logic bg_quiet,
  output logic [`RBA_ELEM_BITS-1:0] disabled_elems
);
  rba_pkg::main_state_t s_r, s_nxt;
  rba_test_if tif ();

  logic page_hit;
  logic commit_ok;
  logic start_test;
  logic pred_now;
  logic unpred_now;
  logic trk_found;
  logic trk_rep;
  logic [`RBA_LBA_W-1:0] trk_first;
  logic [`RBA_LBA_W-1:0] trk_final;

  // Page byte view; reserved bytes always return zero
  function automatic logic [7:0] page_byte(
    input logic [`RBA_OFF_W-1:0] off,
    input logic en,
    input logic [`RBA_ELEM_BITS-1:0] dis
  );
    logic [7:0] b;
    b = 8'h00;
    if (off == `RBA_OFS_ENABLE) begin
      b[`RBA_EN_BIT] = en;
    end else if (off == `RBA_OFS_LEN) begin
      b = `RBA_ELEM_LEN;
    end else if (off == `RBA_OFS_MASK_HI) begin
      b = 8'(`RBA_ELEM_MASK >> 8);
    end else if (off == `RBA_OFS_MASK_LO) begin
      b = 8'(`RBA_ELEM_MASK & 16'h00FF);
    end else if (off == `RBA_OFS_DIS_HI) begin
      b = dis[15:8];
    end else if (off == `RBA_OFS_DIS_LO) begin
      b = dis[7:0];
    end
    return b;
  endfunction : page_byte

  // The page is only served at its own log address
  assign page_hit = (log_page == `RBA_LOG_ADDR);
  assign feature_supported = 1'b1;

  // A commit during the self test is dropped; log_busy tells the host
  assign commit_ok = log_commit && page_hit &&
                     s_r.mode == rba_pkg::MODE_IDLE;
  assign start_test = commit_ok && s_r.stg_en;
  assign tif.start = start_test;
  assign tif.mask = `RBA_ELEM_MASK;

  // Bypass only exists on reads; writes always see the feature
  assign pred_now = sec_valid && s_r.enabled &&
                    s_r.dis[sec_elem] &&
                    !(!sec_write && rebuild_assist_bypass);
  assign unpred_now = sec_valid && sec_media_err && !pred_now;

  // Next state of the log page and enable sequence
  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.pred = pred_now;
    s_nxt.unpred = unpred_now;
    if (log_rd && page_hit) begin
      s_nxt.rdata = page_byte(log_off, s_r.enabled, s_r.dis);
      s_nxt.rvalid = 1'b1;
    end
    // Length, mask and reserved bytes have no staging: writes vanish
    if (log_wr && page_hit) begin
      if (log_off == `RBA_OFS_ENABLE) begin
        s_nxt.stg_en = log_wdata[`RBA_EN_BIT];
      end else if (log_off == `RBA_OFS_DIS_HI) begin
        s_nxt.stg_dis[15:8] = log_wdata;
      end else if (log_off == `RBA_OFS_DIS_LO) begin
        s_nxt.stg_dis[7:0] = log_wdata;
      end
    end
    if (start_test) begin
      s_nxt.mode = rba_pkg::MODE_TEST;
      s_nxt.enabled = 1'b0;
    end else if (commit_ok) begin
      s_nxt.enabled = 1'b0;
      s_nxt.dis = s_r.stg_dis & `RBA_ELEM_MASK;
    end
    if (s_r.mode == rba_pkg::MODE_TEST && tif.done) begin
      s_nxt.mode = rba_pkg::MODE_IDLE;
      s_nxt.enabled = 1'b1;
      s_nxt.dis = tif.fail & `RBA_ELEM_MASK;
    end
  end

  // Power cycle is the reset: feature off, nothing disabled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r.mode <= rba_pkg::MODE_IDLE;
      s_r.enabled <= 1'b0;
      s_r.stg_en <= 1'b0;
      s_r.stg_dis <= `RBA_DIS_RESET;
      s_r.dis <= `RBA_DIS_RESET;
      s_r.rdata <= 8'h00;
      s_r.rvalid <= 1'b0;
      s_r.pred <= 1'b0;
      s_r.unpred <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Element walker
  rba_self_test rba_self_test_inst (
    .clk(clk),
    .nrst(nrst),
    .tif(tif.tst),
    .elem_test_req(elem_test_req),
    .elem_test_idx(elem_test_idx),
    .elem_test_ack(elem_test_ack),
    .elem_test_ok(elem_test_ok)
  );

  // First predicted run of each command
  rba_run_tracker rba_run_tracker_inst (
    .clk(clk),
    .nrst(nrst),
    .sec_valid(sec_valid),
    .sec_last(sec_last),
    .sec_lba(sec_lba),
    .pred(pred_now),
    .unpred(unpred_now),
    .report(!sec_write && !rebuild_assist_bypass),
    .done(cmd_done),
    .err(cmd_err),
    .found(trk_found),
    .rep(trk_rep),
    .first_lba(trk_first),
    .final_lba(trk_final)
  );

  // Outputs; queued log entry only for reads without bypass
  assign log_rdata = s_r.rdata;
  assign log_rvalid = s_r.rvalid;
  assign log_busy = (s_r.mode == rba_pkg::MODE_TEST);
  assign bg_quiet = (s_r.mode == rba_pkg::MODE_TEST);
  assign feature_enabled = s_r.enabled;
  assign disabled_elems = s_r.dis;
  assign sec_pred_err = s_r.pred;
  assign sec_unpred_err = s_r.unpred;
  assign qel_valid = cmd_done && trk_found && trk_rep;
  assign qel_sense_key = `RBA_SENSE_KEY;
  assign qel_asc = `RBA_ASC_ASCQ;
  assign qel_lba = trk_first;
  assign qel_final_lba = trk_final;

  // Checks on the documented behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_LEN_RO: assert property (
    log_rd && page_hit && log_off == `RBA_OFS_LEN
    |=> log_rvalid && log_rdata == 8'h02)
    else $error("length byte not constant");

  AST_MASK_RO: assert property (
    log_rd && page_hit && log_off == `RBA_OFS_MASK_HI
    |=> log_rdata == 8'h0F)
    else $error("mask high byte wrong");

  AST_RESVD: assert property (
    log_rd && page_hit && log_off > `RBA_OFS_DIS_LO
    |=> log_rdata == 8'h00)
    else $error("reserved byte not zero");

  AST_PRED: assert property (
    sec_valid && feature_enabled && disabled_elems[sec_elem] &&
    sec_write
    |=> sec_pred_err && !sec_unpred_err)
    else $error("disabled element write not predicted");

  AST_NOPRED: assert property (
    sec_valid && !disabled_elems[sec_elem] |=> !sec_pred_err)
    else $error("prediction on working element");

  AST_BYPASS: assert property (
    sec_valid && !sec_write && rebuild_assist_bypass
    |=> !sec_pred_err)
    else $error("bypass read affected by feature");

  AST_START: assert property (
    start_test |=> log_busy && !feature_enabled ##1 elem_test_idx == 4'h0)
    else $error("self test not started");

  AST_LOAD: assert property (
    log_busy && tif.done
    |=> feature_enabled && !log_busy &&
        disabled_elems == ($past(tif.fail) & 16'h0FFF))
    else $error("disabled bits not seeded");

  AST_QUIET: assert property (
    log_busy |-> bg_quiet)
    else $error("background not quiet while testing");

  AST_DISABLE: assert property (
    commit_ok && !s_r.stg_en |=> !feature_enabled [*2])
    else $error("feature not disabled");

  AST_QEL: assert property (
    qel_valid |-> qel_sense_key == 4'hB && qel_asc == 16'h1103 &&
    qel_final_lba >= qel_lba)
    else $error("queued log entry wrong");

  AST_GOOD: assert property (
    sec_valid && sec_last && !pred_now && !unpred_now &&
    !rba_run_tracker_inst.s_r.any_err |=> cmd_done && !cmd_err)
    else $error("clean read reported error");

  // Log page answers; reads are one cycle behind their request
  AST_RD_ACK: assert property (
    log_rd && page_hit |=> log_rvalid)
    else $error("page read not answered");

  AST_EN_RD: assert property (
    log_rd && page_hit && log_off == `RBA_OFS_ENABLE
    |=> log_rdata == {7'h00, $past(feature_enabled)})
    else $error("enable flag read back wrong");

  AST_MASK_LO: assert property (
    log_rd && page_hit && log_off == `RBA_OFS_MASK_LO
    |=> log_rdata == 8'hFF)
    else $error("mask low byte wrong");

  AST_DIS_HI: assert property (
    log_rd && page_hit && log_off == `RBA_OFS_DIS_HI
    |=> {8'h00, log_rdata} == ($past(disabled_elems) >> 8))
    else $error("disabled high byte wrong");

  AST_DIS_LO: assert property (
    log_rd && page_hit && log_off == `RBA_OFS_DIS_LO
    |=> {8'h00, log_rdata} == ($past(disabled_elems) & 16'h00FF))
    else $error("disabled low byte wrong");

  AST_RESVD_LO: assert property (
    log_rd && page_hit && log_off > `RBA_OFS_ENABLE &&
    log_off < `RBA_OFS_LEN |=> log_rdata == 8'h00)
    else $error("reserved byte below length not zero");

  // Unsupported element bits can never be disabled
  AST_DIS_SUP: assert property (
    (disabled_elems & 16'hF000) == 16'h0000)
    else $error("unsupported element disabled");

  AST_DIS_COMMIT: assert property (
    commit_ok && !s_r.stg_en
    |=> disabled_elems == ($past(s_r.stg_dis) & 16'h0FFF))
    else $error("disable commit lost staged bits");

  AST_TEST_OFF: assert property (
    log_busy |-> !feature_enabled)
    else $error("enabled while self test runs");

  // Sector verdicts
  AST_PRED_RD: assert property (
    sec_valid && feature_enabled && disabled_elems[sec_elem] &&
    !sec_write && !rebuild_assist_bypass
    |=> sec_pred_err && !sec_unpred_err)
    else $error("disabled element read not predicted");

  AST_UNPRED: assert property (
    sec_valid && sec_media_err && !disabled_elems[sec_elem]
    |=> sec_unpred_err && !sec_pred_err)
    else $error("media error not reported as unpredicted");

  AST_EXCL: assert property (
    !(sec_pred_err && sec_unpred_err))
    else $error("error reported both ways");

  AST_CMD_END: assert property (
    sec_valid && sec_last |=> cmd_done)
    else $error("command did not complete");

  AST_QEL_WR: assert property (
    cmd_done && $past(sec_write) |-> !qel_valid)
    else $error("write command logged as read error");

  COV_ENABLE: cover property (start_test ##[1:200] feature_enabled);
  COV_QEL: cover property (qel_valid && qel_final_lba != qel_lba);
  COV_DISABLE: cover property (feature_enabled ##1 !feature_enabled);
endmodule : rba_log_control
`default_nettype wire

// [bench/rba_media_model.sv]
// Media side model that answers element self-test requests
`timescale 1ns/1ps
`default_nettype none
module rba_media_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Test request from the block
  input wire logic req,
  input wire logic [3:0] idx,
  // Scenario controls
  input wire logic [15:0] fail_pat,
  input wire logic [3:0] delay,
  // Answer
  output logic ack,
  output logic ok
);
  logic [3:0] cnt_r;

  // Ack after delay cycles; ok toggles outside ack so it is never trusted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 4'h0;
      ack <= 1'b0;
      ok <= 1'b0;
    end else if (req && !ack && cnt_r == delay) begin
      cnt_r <= 4'h0;
      ack <= 1'b1;
      ok <= !fail_pat[idx];
    end else begin
      cnt_r <= (req && !ack) ? cnt_r + 4'h1 : 4'h0;
      ack <= 1'b0;
      ok <= !ok;
    end
  end
endmodule : rba_media_model
`default_nettype wire

// [bench/rebuild_assist_log_control_tb_top.sv]
// Self-checking bench for the rebuild assist log control
`timescale 1ns/1ps
`default_nettype none
`include "rba_params.svh"
module rebuild_assist_log_control_tb_top;
  logic clk, nrst, log_rd, log_wr, log_commit, log_rvalid, log_busy;
  logic [7:0] log_page, log_wdata, log_rdata;
  logic [8:0] log_off;
  logic feature_supported, elem_test_req, elem_test_ack, elem_test_ok;
  logic [3:0] elem_test_idx, sec_elem, qel_sense_key, delay;
  logic sec_valid, sec_write, rebuild_assist_bypass, sec_media_err, sec_last;
  logic sec_pred_err, sec_unpred_err, cmd_done, cmd_err, qel_valid;
  logic [15:0] qel_asc, disabled_elems, fail_pat;
  logic [47:0] sec_lba, qel_lba, qel_final_lba;
  logic feature_enabled, bg_quiet;
  int error_cnt, samples_checked;

  rba_log_control rba_log_control_inst (
    .clk, .nrst, .feature_supported, .log_page, .log_rd, .log_wr,
    .log_off, .log_wdata, .log_commit, .log_rdata, .log_rvalid,
    .log_busy, .elem_test_req, .elem_test_idx, .elem_test_ack,
    .elem_test_ok, .sec_valid, .sec_lba, .sec_elem, .sec_write,
    .rebuild_assist_bypass, .sec_media_err, .sec_last, .sec_pred_err,
    .sec_unpred_err, .cmd_done, .cmd_err, .qel_valid, .qel_sense_key,
    .qel_asc, .qel_lba, .qel_final_lba, .feature_enabled, .bg_quiet,
    .disabled_elems);

  rba_media_model rba_media_model_inst (
    .clk, .nrst, .req(elem_test_req), .idx(elem_test_idx), .fail_pat,
    .delay, .ack(elem_test_ack), .ok(elem_test_ok));

  // 250 MHz clock
  always #2 clk = ~clk;

  task automatic report_and_stop();
    $display("Mismatches %0d, checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask : chk

  // Page read: rvalid and data are looked at one cycle after the request
  task automatic rd(input logic [8:0] o, input logic [7:0] e);
    @(posedge clk);
    log_rd <= 1'b1;
    log_off <= o;
    @(posedge clk);
    log_rd <= 1'b0;
    @(negedge clk);
    chk(log_rvalid, 1'b1);
    chk(log_rdata, e);
  endtask : rd

  task automatic wr(input logic [8:0] o, input logic [7:0] d);
    @(posedge clk);
    log_wr <= 1'b1;
    log_off <= o;
    log_wdata <= d;
    @(posedge clk);
    log_wr <= 1'b0;
  endtask : wr

  task automatic commit();
    @(posedge clk);
    log_commit <= 1'b1;
    @(posedge clk);
    log_commit <= 1'b0;
    @(negedge clk);
  endtask : commit

  // One sector; verdict pulses and completion are seen a cycle later
  task automatic sec(input logic [47:0] l, input logic [3:0] el,
                     input logic w, b, m, la, ep, eu);
    @(posedge clk);
    sec_valid <= 1'b1;
    sec_lba <= l;
    sec_elem <= el;
    sec_write <= w;
    rebuild_assist_bypass <= b;
    sec_media_err <= m;
    sec_last <= la;
    @(posedge clk);
    sec_valid <= 1'b0;
    @(negedge clk);
    chk(sec_pred_err, ep);
    chk(sec_unpred_err, eu);
    chk(cmd_done, la);
  endtask : sec

  task automatic reset_values();
    chk(feature_supported, 1'b1);
    chk(feature_enabled, 1'b0);
    chk(disabled_elems, 16'h0000);
    rd(9'h000, 8'h00);
    rd(9'h007, `RBA_ELEM_LEN);
    rd(9'h008, 8'h0F);
    rd(9'h009, 8'hFF);
    rd(9'h00A, 8'h00);
    rd(9'h00B, 8'h00);
    rd(9'h001, 8'h00);
    rd(9'h00C, 8'h00);
    rd(9'h1FF, 8'h00);
  endtask : reset_values

  task automatic ro_writes();
    wr(9'h007, 8'hFF);
    wr(9'h008, 8'h00);
    wr(9'h009, 8'h00);
    wr(9'h001, 8'hAA);
    wr(9'h1FF, 8'h55);
    commit();
    rd(9'h007, 8'h02);
    rd(9'h008, 8'h0F);
    rd(9'h009, 8'hFF);
    rd(9'h001, 8'h00);
    rd(9'h1FF, 8'h00);
  endtask : ro_writes

  // Only log address 15h is served
  task automatic foreign_page();
    @(posedge clk);
    log_page <= 8'h16;
    wr(9'h000, 8'h01);
    commit();
    chk(log_busy, 1'b0);
    chk(feature_enabled, 1'b0);
    @(posedge clk);
    log_page <= 8'h15;
  endtask : foreign_page

  task automatic enable_test(input logic [15:0] pat, input logic [3:0] dl);
    int n;
    n = 0;
    @(posedge clk);
    fail_pat <= pat;
    delay <= dl;
    wr(9'h000, 8'h01);
    commit();
    chk(log_busy, 1'b1);
    chk(elem_test_req, 1'b1);
    chk(bg_quiet, 1'b1);
    while (feature_enabled !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(n < 400, 1'b1);
    chk(bg_quiet, 1'b0);
    chk(disabled_elems, pat & `RBA_ELEM_MASK);
    rd(9'h000, 8'h01);
    rd(9'h00A, pat[15:8] & 8'h0F);
    rd(9'h00B, pat[7:0]);
  endtask : enable_test

  // Ascending LBA order
  task automatic read_cmds();
    sec(48'h64, 4'h1, 0, 0, 0, 0, 1, 0);
    sec(48'h65, 4'h3, 0, 0, 1, 0, 1, 0);
    sec(48'h66, 4'h0, 0, 0, 1, 0, 0, 1);
    sec(48'h67, 4'h3, 0, 0, 0, 1, 1, 0);
    chk(cmd_err, 1'b1);
    chk(qel_valid, 1'b1);
    chk(qel_sense_key, `RBA_SENSE_KEY);
    chk(qel_asc, `RBA_ASC_ASCQ);
    chk(qel_lba, 48'h64);
    chk(qel_final_lba, 48'h65);
    sec(48'hC8, 4'h1, 0, 1, 0, 1, 0, 0);
    chk(cmd_err, 1'b0);
    chk(qel_valid, 1'b0);
    sec(48'h12C, 4'h3, 1, 0, 0, 1, 1, 0);
    chk(qel_valid, 1'b0);
  endtask : read_cmds

  task automatic disable_test();
    wr(9'h000, 8'h00);
    wr(9'h00A, 8'hF0);
    wr(9'h00B, 8'h05);
    commit();
    chk(feature_enabled, 1'b0);
    chk(disabled_elems, 16'h0005);
    rd(9'h000, 8'h00);
    sec(48'h12D, 4'h0, 0, 0, 0, 1, 0, 0);
  endtask : disable_test

  // Reset stands for a power cycle
  task automatic power_cycle();
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk(feature_enabled, 1'b0);
    chk(disabled_elems, 16'h0000);
    rd(9'h000, 8'h00);
  endtask : power_cycle

  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    {log_rd, log_wr, log_commit, sec_valid, sec_write} = '0;
    {rebuild_assist_bypass, sec_media_err, sec_last} = '0;
    log_page = 8'h15;
    log_off = 9'h000;
    log_wdata = 8'h00;
    sec_lba = 48'h0;
    sec_elem = 4'h0;
    fail_pat = 16'h0000;
    delay = 4'h0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    reset_values();
    ro_writes();
    foreign_page();
    enable_test(16'hF00A, 4'h3);
    read_cmds();
    disable_test();
    enable_test(16'h8001, 4'h0);
    power_cycle();
    report_and_stop();
  end

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #(20000 * 4);
    error_cnt++;
    report_and_stop();
  end
endmodule : rebuild_assist_log_control_tb_top
`default_nettype wire
